// [shared/irq_ctrl_defines.svh]
// Purpose: Constants of the multilevel interrupt controller
// Assumes: Word addresses of program memory, 16 bits wide
// Notes:   Definitions only; included by bare name
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// ==========================================================
// Source count and index width
`define IRQ_NSRC         11
`define IRQ_IDX_W        4

// ==========================================================
// Vector table, program word addresses
`define IRQ_VEC_RESET    16'h0000
`define IRQ_VEC_OSC_NMI  16'h0002
`define IRQ_VEC_PORT_R   16'h0004
`define IRQ_BASE_DMA     16'h0006
`define IRQ_BASE_RTC     16'h000e
`define IRQ_VEC_PORT_C   16'h0012
`define IRQ_BASE_TWO_W   16'h0014
`define IRQ_BASE_TIMER4  16'h0018

// ==========================================================
// Offsets of vectors inside a peripheral
`define IRQ_OFS_0        16'h0000
`define IRQ_OFS_1        16'h0002
`define IRQ_OFS_2        16'h0004
`define IRQ_OFS_3        16'h0006

// ==========================================================
// Default start of the boot loader area (word address)
`define IRQ_BOOT_BASE    16'h4000

`endif

// [shared/irq_ctrl_pkg.sv]
// Purpose: Types of the multilevel interrupt controller
// Assumes: Two-bit level code per source
// Notes:   Constants live in irq_ctrl_defines.svh
package irq_ctrl_pkg;

	// ======================================================
	// Level code of one source, off means not configured
	typedef enum logic [1:0] {
		LVL_OFF,
		LVL_LOW,
		LVL_MED,
		LVL_HIGH
	} level_t;

endpackage

// [rtl/irq_pick.sv]
// Purpose: Picks one request of a request vector
// Assumes: Index 0 holds the lowest vector address
// Notes:   Purely combinational; rotation start comes from the caller
`timescale 1ns/1ps

module irq_pick #(
	parameter int N  = 11,
	parameter int IW = 4
) (
	// Requests and rotation control
	input  wire logic [N-1:0]  req_i,
	input  wire logic          rr_en_i,
	input  wire logic [IW-1:0] last_i,
	// Result
	output logic               found_o,
	output logic [IW-1:0]      idx_o
);

	// ======================================================
	// Search from lowest index, or from one past the last winner
	always_comb
	begin
		int k;
		int start;
		k       = 0;
		start   = rr_en_i ? (int'(last_i) + 1) % N : 0;
		found_o = 1'b0;
		idx_o   = '0;
		for (int j = 0; j < N; j++)
		begin
			k = (start + j) % N;
			if (!found_o && req_i[k])                    // RULE6
			begin
				found_o = 1'b1;
				idx_o   = IW'(k);
			end
		end
	end

endmodule // irq_pick

// [rtl/multilevel_irq_ctrl.sv]
// Purpose: Multilevel interrupt controller in front of the processor core
// Assumes: Source conditions come from logic on mclk_i; core says when it may be interrupted
// Notes:   Source index order equals vector address order
//
// How it works
// RULE1: Request needs condition, enable and configured level
// RULE2: Acknowledge loads program counter with vector
// RULE3: Each source picks low, medium or high
// RULE4: Medium request preempts a low handler
// RULE5: High request preempts medium and low handlers
// RULE6: Same level: lowest vector address wins
// RULE7: Optional round robin among low requests
// RULE8: Non-maskable request ignores level enables
// RULE9: Vector is peripheral base plus offset
// RULE10: Reset 0x0000, oscillator NMI 0x0002, port R 0x0004
// RULE11: DMA 0x0006, real-time counter 0x000E, port C 0x0012
// RULE12: Two-wire 0x0014, timer 4 0x0018
// RULE13: Table sits in application or boot area
// RULE14: NMI beats and preempts every level
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module multilevel_irq_ctrl
	import irq_ctrl_pkg::*;
#(
	parameter logic [15:0] BOOT_BASE = `IRQ_BOOT_BASE
) (
	// Clock and reset
	input  wire logic                       mclk_i,
	input  wire logic                       rst_n_i,
	// Peripheral sources
	input  wire logic [`IRQ_NSRC-1:0]       src_cond_i,
	input  wire logic [`IRQ_NSRC-1:0]       src_en_i,
	input  wire logic [2*`IRQ_NSRC-1:0]     src_lvl_i,
	input  wire logic                       nmi_req_i,
	// Configuration
	input  wire logic [2:0]                 lvl_en_i,
	input  wire logic                       rr_en_i,
	input  wire logic                       boot_sel_i,
	// Processor core
	input  wire logic                       cpu_ready_i,
	input  wire logic                       reti_i,
	output logic                            pc_load_o,
	output logic [15:0]                     pc_vector_o,
	output logic [`IRQ_NSRC-1:0]            src_ack_o,
	output logic [2:0]                      active_o,
	output logic                            nmi_active_o
);

	localparam int N  = `IRQ_NSRC;
	localparam int IW = `IRQ_IDX_W;

	// ======================================================
	// Vector of each source, base plus offset
	function automatic logic [15:0] src_vec(input logic [IW-1:0] i);
		case (i)
			4'h0:    src_vec = `IRQ_VEC_PORT_R;                 // RULE10
			4'h1:    src_vec = `IRQ_BASE_DMA + `IRQ_OFS_0;      // RULE11
			4'h2:    src_vec = `IRQ_BASE_DMA + `IRQ_OFS_1;      // RULE9
			4'h3:    src_vec = `IRQ_BASE_DMA + `IRQ_OFS_2;
			4'h4:    src_vec = `IRQ_BASE_DMA + `IRQ_OFS_3;
			4'h5:    src_vec = `IRQ_BASE_RTC + `IRQ_OFS_0;      // RULE11
			4'h6:    src_vec = `IRQ_BASE_RTC + `IRQ_OFS_1;
			4'h7:    src_vec = `IRQ_VEC_PORT_C;                 // RULE11
			4'h8:    src_vec = `IRQ_BASE_TWO_W + `IRQ_OFS_0;    // RULE12
			4'h9:    src_vec = `IRQ_BASE_TWO_W + `IRQ_OFS_1;
			default: src_vec = `IRQ_BASE_TIMER4 + `IRQ_OFS_0;   // RULE12
		endcase
	endfunction

	// Area start; boot area shifts the whole table
	function automatic logic [15:0] area_base(input logic sel);
		area_base = sel ? BOOT_BASE : `IRQ_VEC_RESET;        // RULE13
	endfunction

	// ======================================================
	// Request qualification per level
	logic [N-1:0]    lvl_req [3];                            // Requests per level
	logic [2:0]      lvl_found;                              // Level has a request
	logic [IW-1:0]   lvl_idx [3];                            // Winner per level
	logic [IW-1:0]   rr_last;                                // Last low winner

	always_comb
	begin
		level_t lv;
		lv = LVL_OFF;
		for (int k = 0; k < 3; k++)
			lvl_req[k] = '0;
		for (int i = 0; i < N; i++)
		begin
			lv = level_t'(src_lvl_i[2*i +: 2]);              // RULE3
			// Off code means not configured, so no request at all
			if (lv != LVL_OFF && src_en_i[i] && src_cond_i[i] &&
			    lvl_en_i[int'(lv) - 1])
				lvl_req[int'(lv) - 1][i] = 1'b1;             // RULE1
		end
	end

	// One picker per level; only the low level may rotate
	for (genvar g = 0; g < 3; g++)
	begin : g_pick
		irq_pick #(
			.N  (N),
			.IW (IW)
		) u_pick (
			.req_i   (lvl_req[g]),                           // RULE6
			.rr_en_i ((g == 0) && rr_en_i),                  // RULE7
			.last_i  (rr_last),
			.found_o (lvl_found[g]),
			.idx_o   (lvl_idx[g])
		);
	end

	// ======================================================
	// Grant decision against the running handler level
	logic [2:0]      cur_rank;                               // 0 idle, 1..3 level, 4 NMI
	logic            grant_ok;                               // Core may take one now
	logic            take_nmi;                               // Grant the NMI
	logic            take_src;                               // Grant a peripheral source
	logic [1:0]      take_lvl;                               // Level index granted
	logic [N-1:0]    cand_req;                               // Requests of granted level

	always_comb
	begin
		cur_rank = nmi_active_o ? 3'd4 : active_o[2] ? 3'd3 :
		           active_o[1] ? 3'd2 : active_o[0] ? 3'd1 : 3'd0;
		// No grant while the previous load is being taken
		grant_ok = cpu_ready_i && !pc_load_o;
		take_nmi = grant_ok && nmi_req_i && !nmi_active_o;   // RULE8 RULE14
		take_src = 1'b0;
		take_lvl = 2'd0;
		if (lvl_found[2] && cur_rank < 3'd3)
		begin
			take_src = 1'b1;                                 // RULE5
			take_lvl = 2'd2;
		end
		else if (lvl_found[1] && cur_rank < 3'd2)
		begin
			take_src = 1'b1;                                 // RULE4
			take_lvl = 2'd1;
		end
		else if (lvl_found[0] && cur_rank == 3'd0)
		begin
			take_src = 1'b1;
			take_lvl = 2'd0;
		end
		take_src = take_src && grant_ok && !take_nmi;        // RULE14
		cand_req = lvl_req[take_lvl];
	end

	// ======================================================
	// Next state of handler tracking and core outputs
	logic            next_pc_load;
	logic [15:0]     next_pc_vector;
	logic [N-1:0]    next_src_ack;
	logic [2:0]      next_active;
	logic            next_nmi_active;
	logic [IW-1:0]   next_rr_last;

	always_comb
	begin
		next_active     = active_o;
		next_nmi_active = nmi_active_o;
		next_rr_last    = rr_last;
		next_pc_load    = 1'b0;
		next_src_ack    = '0;
		next_pc_vector  = pc_vector_o;
		// Return ends the most urgent running handler first
		if (reti_i)
		begin
			if (nmi_active_o)
				next_nmi_active = 1'b0;
			else if (active_o[2])
				next_active[2] = 1'b0;
			else if (active_o[1])
				next_active[1] = 1'b0;
			else
				next_active[0] = 1'b0;
		end
		if (take_nmi)
		begin
			next_nmi_active = 1'b1;
			next_pc_load    = 1'b1;
			next_pc_vector  = area_base(boot_sel_i) + `IRQ_VEC_OSC_NMI; // RULE2 RULE10
		end
		else if (take_src)
		begin
			next_active[take_lvl]            = 1'b1;
			next_pc_load                     = 1'b1;
			next_src_ack[lvl_idx[take_lvl]]  = 1'b1;
			next_pc_vector = area_base(boot_sel_i) + src_vec(lvl_idx[take_lvl]); // RULE2 RULE9
			if (take_lvl == 2'd0)
				next_rr_last = lvl_idx[0];                   // RULE7
		end
	end

	// Registers only
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			pc_load_o    <= 1'b0;
			pc_vector_o  <= `IRQ_VEC_RESET;
			src_ack_o    <= '0;
			active_o     <= 3'h0;
			nmi_active_o <= 1'b0;
			rr_last      <= IW'(N - 1);
		end
		else
		begin
			pc_load_o    <= next_pc_load;
			pc_vector_o  <= next_pc_vector;
			src_ack_o    <= next_src_ack;
			active_o     <= next_active;
			nmi_active_o <= next_nmi_active;
			rr_last      <= next_rr_last;
		end
	end

	// ======================================================
	// Checks; helper decodes the acknowledged index
	logic [IW-1:0]   ack_idx;                                // Index of one-hot ack

	always_comb
	begin
		ack_idx = '0;
		for (int i = 0; i < N; i++)
			if (src_ack_o[i])
				ack_idx = IW'(i);
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	req_needs_en_a: assert property ((src_ack_o & ~$past(src_en_i)) == '0) // RULE1
		else $error("ack for a disabled source");
	vec_on_load_a: assert property (pc_load_o && src_ack_o != '0 |->
		pc_vector_o == area_base($past(boot_sel_i)) + src_vec(ack_idx)) // RULE2
		else $error("wrong vector on acknowledge");
	ack_onehot_a: assert property ($onehot0(src_ack_o) && (src_ack_o == '0 || pc_load_o)) // RULE2
		else $error("ack not one-hot with load");
	med_preempt_a: assert property (cpu_ready_i && !pc_load_o && active_o == 3'b001 &&
		!reti_i && !nmi_active_o && !nmi_req_i && lvl_found[1] && !lvl_found[2] |=>
		pc_load_o && active_o == 3'b011) // RULE4
		else $error("medium did not preempt low");
	high_preempt_a: assert property (cpu_ready_i && !pc_load_o && active_o[2] == 1'b0 &&
		!nmi_active_o && !nmi_req_i && lvl_found[2] |=> pc_load_o && active_o[2]) // RULE5
		else $error("high did not preempt");
	lowest_wins_a: assert property (pc_load_o && src_ack_o != '0 && !$past(rr_en_i) |->
		(($past(cand_req) & (src_ack_o - 1'b1)) == '0)) // RULE6
		else $error("lower vector skipped");
	rr_rotates_a: assert property (pc_load_o && $past(rr_en_i) && $past(take_lvl) == 2'd0 &&
		src_ack_o != '0 && ($past(cand_req) & ~(N'(1) << $past(rr_last))) != '0 |->
		ack_idx != $past(rr_last)) // RULE7
		else $error("round robin repeated winner");
	nmi_first_a: assert property (cpu_ready_i && !pc_load_o && nmi_req_i && !nmi_active_o |=>
		pc_load_o && nmi_active_o && src_ack_o == '0 &&
		pc_vector_o == area_base($past(boot_sel_i)) + `IRQ_VEC_OSC_NMI) // RULE8 RULE14
		else $error("NMI not granted first");
	boot_area_a: assert property (pc_load_o && $past(boot_sel_i) |->
		pc_vector_o >= BOOT_BASE) // RULE13
		else $error("vector outside boot area");

	low_grant_c:  cover property (pc_load_o && active_o == 3'b001);
	nest_three_c: cover property (active_o == 3'b111 ##1 nmi_active_o);
	rr_turn_c:    cover property (rr_en_i && pc_load_o && src_ack_o[0] ##[1:20] pc_load_o && src_ack_o[1]);

endmodule // multilevel_irq_ctrl

// [verification/irq_core_model.sv]
// Purpose: Processor core stand-in on the far side of the controller
// Assumes: Handlers end by a one-cycle return pulse
// Notes:   Slow mode stretches handlers and drops ready every other cycle
`timescale 1ns/1ps

module irq_core_model (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// From the controller
	input  wire logic       pc_load_i,
	input  wire logic [2:0] active_i,
	input  wire logic       nmi_active_i,
	input  wire logic       slow_i,
	// To the controller
	output logic            cpu_ready_o,
	output logic            reti_o
);
	// ==========================================================
	// Handler timing
	logic [3:0] cnt;       // Cycles since last vector load
	logic [3:0] next_cnt;  // Next value of cnt
	logic       fire;      // Return issued next cycle
	logic       next_rdy;  // Next ready level

	// Return only while a handler runs; ready low then, so a return
	// never meets a grant in the same cycle
	always_comb
	begin
		next_cnt = pc_load_i ? 4'h0 : cnt + 4'h1;
		fire = (|active_i | nmi_active_i) && !reti_o
			&& (slow_i ? cnt == 4'hf : cnt[1:0] == 2'h3);
		next_rdy = !fire && !(slow_i && cnt[0]);
	end

	// Registers only
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			cnt         <= 4'h0;
			reti_o      <= 1'b0;
			cpu_ready_o <= 1'b0;
		end
		else
		begin
			cnt         <= next_cnt;
			reti_o      <= fire;
			cpu_ready_o <= next_rdy;
		end
	end
endmodule // irq_core_model

// [verification/multilevel_irq_ctrl_bench.sv]
// Purpose: Self-checking bench of the interrupt controller
// Assumes: Peripherals drop a condition once it is acknowledged
// Notes:   Phase 0 fixed priority, phase 1 round robin and slow core
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	$display("Error %s expected %h seen %h", nm, ex, got); n_fail++; end end

module multilevel_irq_ctrl_bench;
	import irq_ctrl_pkg::*;
	localparam logic [15:0] BOOT = 16'h2000; // Boot area base under test
	// ==========================================================
	// Signals
	logic        mclk_i, rst_n, nmi, rr_en, boot_sel, slow, rdy, reti;
	logic [10:0] cond, en, ack, e_ack;
	logic [21:0] lvl;
	logic [2:0]  lvl_en, act, e_act;
	logic        pc_load, nmi_act, e_load, e_nmi, e_prev;
	logic [15:0] pc_vec, e_vec;
	logic [31:0] seed;
	int          n_fail, samples_checked, rr_ptr, gi, gl, run, i;
	// Vector of each source index, lowest address first
	logic [15:0] tbl [11] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c,
		16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018};

	multilevel_irq_ctrl #(.BOOT_BASE(BOOT)) i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n),
		.src_cond_i(cond), .src_en_i(en), .src_lvl_i(lvl), .nmi_req_i(nmi),
		.lvl_en_i(lvl_en), .rr_en_i(rr_en), .boot_sel_i(boot_sel), .cpu_ready_i(rdy),
		.reti_i(reti), .pc_load_o(pc_load), .pc_vector_o(pc_vec), .src_ack_o(ack),
		.active_o(act), .nmi_active_o(nmi_act));
	irq_core_model i_core (.mclk_i(mclk_i), .rst_n_i(rst_n), .pc_load_i(pc_load),
		.active_i(act), .nmi_active_i(nmi_act), .slow_i(slow), .cpu_ready_o(rdy),
		.reti_o(reti));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Source raises a request only when enabled and at an enabled level
	function automatic bit qual(input int s, input int l);
		return cond[s] && en[s] && lvl[2*s+:2] == l && lvl_en[l-1];
	endfunction

	task automatic print_verdict;
		$display("Checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// Clock and watchdog
	initial
	begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end
	initial
	begin
		repeat (12000) @(posedge mclk_i);
		n_fail++;
		print_verdict();
	end

	// ==========================================================
	// Reference model, sees inputs as the design samples them
	always @(posedge mclk_i)
	begin
		if (!rst_n)
		begin
			{e_load, e_nmi, e_ack, e_act, e_vec} = '0;
			rr_ptr = 10;
		end
		else
		begin
			if (reti)
			begin
				if (e_nmi) e_nmi = 1'b0;
				else if (e_act[2]) e_act[2] = 1'b0;
				else if (e_act[1]) e_act[1] = 1'b0;
				else e_act[0] = 1'b0;
			end
			run = e_act[2] ? 3 : e_act[1] ? 2 : e_act[0] ? 1 : 0;
			gi = -1;
			// Load standing at this edge refuses every grant, source ones too
			e_prev = e_load;
			if (rdy && !e_load && nmi && !e_nmi)
			begin
				// Non-maskable beats every level
				e_nmi = 1'b1;
				e_vec = `IRQ_VEC_OSC_NMI + (boot_sel ? BOOT : 16'h0000);
				e_ack = '0;
				e_load = 1'b1;
			end
			else
			begin
				e_load = 1'b0;
				e_ack = '0;
				if (rdy && !e_nmi && !e_prev)
					for (int l = 3; l > run && gi < 0; l--)
						for (int k = 0; k < 11; k++)
						begin
							i = (l == 1 && rr_en) ? (rr_ptr + 1 + k) % 11 : k;
							if (gi < 0 && qual(i, l))
							begin
								gi = i;
								gl = l;
							end
						end
				if (gi >= 0)
				begin
					e_load = 1'b1;
					e_ack[gi] = 1'b1;
					e_act[gl-1] = 1'b1;
					e_vec = tbl[gi] + (boot_sel ? BOOT : 16'h0000);
					if (gl == 1) rr_ptr = gi;
				end
			end
		end
	end

	// Every result compared once settled
	always @(negedge mclk_i)
	begin
		if (rst_n)
		begin
			`CHK("pc_load", e_load, pc_load)
			`CHK("pc_vector", e_vec, pc_vec)
			`CHK("src_ack", e_ack, ack)
			`CHK("active", e_act, act)
			`CHK("nmi_active", e_nmi, nmi_act)
		end
	end

	// ==========================================================
	// Random traffic; conditions fall once acknowledged
	initial
	begin
		{cond, en, lvl, nmi, lvl_en, rr_en, boot_sel, slow, rst_n} = '0;
		seed = 32'h398114f9;
		for (int ph = 0; ph < 2; ph++)
		begin
			rst_n <= 1'b0;
			repeat (10) @(posedge mclk_i);
			rst_n <= 1'b1;
			rr_en <= ph[0];
			slow <= ph[0];
			for (int c = 0; c < 3000; c++)
			begin
				@(posedge mclk_i);
				seed = xs(seed);
				cond <= (cond | (seed[10:0] & seed[21:11] & seed[31:21])) & ~ack;
				nmi <= nmi ? !nmi_act : seed[31:26] == 6'h00;
				if (c == 0 || seed[5:0] == 6'h00)
				begin
					seed = xs(seed);
					en <= seed[10:0] | seed[31:21];
					lvl <= seed[21:0];
					lvl_en <= seed[26] ? seed[24:22] : 3'b111;
					boot_sel <= seed[27];
				end
			end
		end
		print_verdict();
	end
endmodule // multilevel_irq_ctrl_bench
